// [design/cpu_int_sel_pkg.sv]
`default_nettype none
package cpu_int_sel_pkg;

  // ****************************************************************
  // Register map and bus carriers
  // ****************************************************************
  localparam logic [31:0] ADDR_SELECT_HIGH = 32'h019C_0000; // Lines 10 to 15
  localparam logic [31:0] ADDR_SELECT_LOW = 32'h019C_0004;  // Lines 4 to 9
  localparam logic [31:0] ADDR_EVENT_STATUS = 32'h019C_0008; // Sticky events, write one clears
  localparam logic [31:0] ADDR_EVENT_MASK = 32'h019C_000C;  // Enables onto irq_out

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } wb_req_t;

  // Classic Wishbone answer from this slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // ****************************************************************
  // Selector field layout and reset values
  // ****************************************************************
  localparam int FIELDS_PER_REG = 6;     // Selector fields in one register
  localparam int CODE_W = 5;             // Width of one selector code
  localparam int FIRST_MASKABLE = 4;     // Lowest programmable CPU line
  localparam int NUM_CPU_LINES = 16;     // Lines presented to the core
  localparam int NUM_CODES = 32;         // Source slots addressed by a code
  localparam logic [31:0] SELECT_WRITABLE = 32'h7FFF_7FFF; // Bits 15 and 31 unused
  localparam logic [31:0] SELECT_LOW_RESET = 32'h2507_18A4;
  localparam logic [31:0] SELECT_HIGH_RESET = 32'h0820_2D43;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int STATUS_BITS = 2;        // Implemented status and mask bits
  localparam int EVT_RESERVED_CODE = 0;  // A reserved code was written
  localparam int EVT_SELECT_CHANGED = 1; // A selector register was rewritten

  // ****************************************************************
  // Selector codes: position of each source in the event vector
  // ****************************************************************
  localparam logic [4:0] CODE_HOST_TO_DSP = 5'h00;
  localparam logic [4:0] CODE_TIMER_ZERO = 5'h01;
  localparam logic [4:0] CODE_TIMER_ONE = 5'h02;
  localparam logic [4:0] CODE_SDRAM_TIMER_A = 5'h03;
  localparam logic [4:0] CODE_PIN_EVENT_FOUR = 5'h04; // 05..07 follow for pins five to seven
  localparam logic [4:0] CODE_DMA_COMPLETION = 5'h08;
  localparam logic [4:0] CODE_EMULATION_TRANSFER = 5'h09;
  localparam logic [4:0] CODE_DEBUG_RECEIVE = 5'h0A;
  localparam logic [4:0] CODE_DEBUG_TRANSMIT = 5'h0B;
  localparam logic [4:0] CODE_SERIAL0_TX = 5'h0C;
  localparam logic [4:0] CODE_SERIAL0_RX = 5'h0D;
  localparam logic [4:0] CODE_SERIAL1_TX = 5'h0E;
  localparam logic [4:0] CODE_SERIAL1_RX = 5'h0F;
  localparam logic [4:0] CODE_PIN_EVENT_ZERO = 5'h10;
  localparam logic [4:0] CODE_SERIAL2_TX = 5'h11;
  localparam logic [4:0] CODE_SERIAL2_RX = 5'h12;
  localparam logic [4:0] CODE_TIMER_TWO = 5'h13;
  localparam logic [4:0] CODE_SDRAM_TIMER_B = 5'h14;
  localparam logic [4:0] CODE_CELL_INTERFACE = 5'h17;
  localparam logic [4:0] CODE_VITERBI_UNIT = 5'h1E;
  localparam logic [4:0] CODE_TURBO_UNIT = 5'h1F;
  // One bit per code: set where the code names a real source
  localparam logic [31:0] CODE_VALID_MAP = 32'hC09F_FFFF;

endpackage
`default_nettype wire

// [design/cpu_interrupt_selector.sv]
// Register access over Wishbone was left to the implementer.
`default_nettype none

module cpu_interrupt_selector (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register bus
  input wire cpu_int_sel_pkg::wb_req_t wb_req_in,
  output var cpu_int_sel_pkg::wb_rsp_t wb_rsp_out,
  // Event sources
  input wire logic reset_event_in,
  input wire logic nmi_event_in,
  input wire logic [31:0] source_events_in,
  // Core side
  output logic [15:0] cpu_int_out,
  output logic irq_out
);
  import cpu_int_sel_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Lowest bit of selector field k inside its register
  function automatic int field_lsb(input int k);
    field_lsb = (k < 3) ? (k * CODE_W) : (k * CODE_W + 1);
  endfunction

  // Selector code for CPU line n, taken from the right register
  function automatic logic [4:0] line_code(input int n, input logic [31:0] low,
                                           input logic [31:0] high);
    logic [31:0] src;
    int k;
    src = (n < FIRST_MASKABLE + FIELDS_PER_REG) ? low : high;
    k = (n - FIRST_MASKABLE) % FIELDS_PER_REG;
    line_code = src[field_lsb(k) +: CODE_W];
  endfunction

  // True when any field of a written word carries a reserved code
  function automatic logic has_reserved(input logic [31:0] word);
    logic bad;
    bad = 1'b0;
    for (int k = 0; k < FIELDS_PER_REG; k++) begin
      bad = bad | ~CODE_VALID_MAP[word[field_lsb(k) +: CODE_W]];
    end
    has_reserved = bad;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [31:0] select_high_r;   // Sources of lines 10 to 15
  logic [31:0] select_low_r;    // Sources of lines 4 to 9
  logic [STATUS_BITS-1:0] status_r; // Sticky block events
  logic [STATUS_BITS-1:0] status_nxt;
  logic [STATUS_BITS-1:0] mask_r;   // Interrupt enables, same layout
  logic ack_r;                  // Bus answer, one cycle
  logic [31:0] rdat_r;          // Read data captured with ack
  logic [15:0] cpu_int_r;       // Registered lines to the core
  logic irq_r;                  // Registered block interrupt
  logic [31:0] rdat_nxt;
  logic [15:0] cpu_int_nxt;
  logic req_live;               // Request present on the bus
  logic wr_fire;                // Write commits at this edge
  logic [31:0] merged;          // Write data after byte lanes
  logic [STATUS_BITS-1:0] evt_set;

  assign req_live = wb_req_in.cyc & wb_req_in.stb;
  // Write lands only on the edge where the master sees ack
  assign wr_fire = req_live & wb_req_in.we & ack_r;

  // ****************************************************************
  // Bus slave: ack and read data
  // ****************************************************************

  // Read mux; unmapped addresses read zero and are still acked
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    unique case (wb_req_in.adr)
      ADDR_SELECT_HIGH: rdat_nxt = select_high_r;
      ADDR_SELECT_LOW: rdat_nxt = select_low_r;
      ADDR_EVENT_STATUS: rdat_nxt[STATUS_BITS-1:0] = status_r;
      ADDR_EVENT_MASK: rdat_nxt[STATUS_BITS-1:0] = mask_r;
      default: rdat_nxt = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req_live & ~ack_r;
      if (req_live && !ack_r) begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  assign wb_rsp_out.ack = ack_r;
  assign wb_rsp_out.dat = rdat_r;

  // ****************************************************************
  // Selector registers
  // ****************************************************************
  assign merged = lane_merge(wb_req_in.adr == ADDR_SELECT_HIGH ? select_high_r : select_low_r,
                             wb_req_in.dat, wb_req_in.sel);

  // Defaults route each maskable line to its reset-time source
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      select_high_r <= SELECT_HIGH_RESET;
      select_low_r <= SELECT_LOW_RESET;
    end else if (wr_fire) begin
      // Unused bits 15 and 31 stay zero whatever is written
      if (wb_req_in.adr == ADDR_SELECT_HIGH) begin
        select_high_r <= merged & SELECT_WRITABLE;
      end
      if (wb_req_in.adr == ADDR_SELECT_LOW) begin
        select_low_r <= merged & SELECT_WRITABLE;
      end
    end
  end

  // ****************************************************************
  // Sticky status, mask and block interrupt
  // ****************************************************************

  // Reserved codes are the writer's fault; flag them, do not refuse them
  always_comb begin
    evt_set = '0;
    if (wr_fire && (wb_req_in.adr == ADDR_SELECT_HIGH ||
                    wb_req_in.adr == ADDR_SELECT_LOW)) begin
      evt_set[EVT_SELECT_CHANGED] = 1'b1;
      evt_set[EVT_RESERVED_CODE] = has_reserved(merged & SELECT_WRITABLE);
    end
  end

  // A new event beats a write-one clear in the same cycle
  always_comb begin
    status_nxt = status_r;
    if (wr_fire && wb_req_in.adr == ADDR_EVENT_STATUS && wb_req_in.sel[0]) begin
      status_nxt = status_r & ~wb_req_in.dat[STATUS_BITS-1:0];
    end
    status_nxt = status_nxt | evt_set;
  end

  // Status and mask registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= STATUS_RESET[STATUS_BITS-1:0];
      mask_r <= MASK_RESET[STATUS_BITS-1:0];
    end else begin
      status_r <= status_nxt;
      if (wr_fire && wb_req_in.adr == ADDR_EVENT_MASK && wb_req_in.sel[0]) begin
        mask_r <= wb_req_in.dat[STATUS_BITS-1:0];
      end
    end
  end

  // Level output, one register stage behind status
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign irq_out = irq_r;

  // ****************************************************************
  // Routing to the core
  // ****************************************************************

  // Fixed lines; reserved lines are held low
  always_comb begin
    cpu_int_nxt = '0;
    cpu_int_nxt[0] = reset_event_in;
    cpu_int_nxt[1] = nmi_event_in;
  end

  // Each maskable line follows the event its field names
  generate
    for (genvar n = FIRST_MASKABLE; n < NUM_CPU_LINES; n++) begin : g_route
      logic [4:0] code;
      assign code = line_code(n, select_low_r, select_high_r);
      // Reserved codes select nothing rather than a stray input
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          cpu_int_r[n] <= 1'b0;
        end else begin
          cpu_int_r[n] <= source_events_in[code] & CODE_VALID_MAP[code];
        end
      end
    end
  endgenerate

  // Fixed lines registered too, so every core input has equal latency
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_int_r[FIRST_MASKABLE-1:0] <= '0;
    end else begin
      cpu_int_r[FIRST_MASKABLE-1:0] <= cpu_int_nxt[FIRST_MASKABLE-1:0];
    end
  end

  assign cpu_int_out = cpu_int_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  logic first_r; // High only for the first edge after reset release
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  sequence s_write_high;
    wr_fire && wb_req_in.adr == ADDR_SELECT_HIGH && wb_req_in.sel == 4'hF;
  endsequence

  sequence s_write_low;
    wr_fire && wb_req_in.adr == ADDR_SELECT_LOW && wb_req_in.sel == 4'hF;
  endsequence

  // The first edge after release still shows the reset value, not the event
  a_fixed_reset_line: assert property (
    !first_r |-> cpu_int_out[0] == $past(reset_event_in))
    else $error("line zero does not follow reset event");

  a_fixed_nmi_reserved: assert property (
    !first_r |-> cpu_int_out[1] == $past(nmi_event_in) && cpu_int_out[3:2] == 2'b00)
    else $error("fixed lines wrong");

  a_default_sources: assert property (
    first_r |-> select_low_r == SELECT_LOW_RESET && select_high_r == SELECT_HIGH_RESET)
    else $error("selector defaults wrong after reset");

  a_low_field_codes: assert property (
    first_r |-> line_code(4, select_low_r, select_high_r) == CODE_PIN_EVENT_FOUR &&
                line_code(8, select_low_r, select_high_r) == CODE_DMA_COMPLETION &&
                line_code(9, select_low_r, select_high_r) == CODE_EMULATION_TRANSFER)
    else $error("low defaults wrong");

  a_high_field_codes: assert property (
    first_r |-> line_code(10, select_low_r, select_high_r) == CODE_SDRAM_TIMER_A &&
                line_code(13, select_low_r, select_high_r) == CODE_HOST_TO_DSP &&
                line_code(15, select_low_r, select_high_r) == CODE_TIMER_ONE)
    else $error("high defaults wrong");

  a_select_write: assert property (
    s_write_high |=> select_high_r == ($past(wb_req_in.dat) & SELECT_WRITABLE))
    else $error("high selector write lost");

  a_unused_bits: assert property (
    s_write_low |=> select_low_r[15] == 1'b0 && select_low_r[31] == 1'b0 &&
                    select_low_r[30:26] == $past(wb_req_in.dat[30:26]))
    else $error("low selector layout wrong");

  a_route_after_write: assert property (
    s_write_low ##1 1'b1 |=> cpu_int_out[4] ==
      $past(source_events_in[select_low_r[4:0]] & CODE_VALID_MAP[select_low_r[4:0]]))
    else $error("line four ignores new selection");

  a_serial_code_route: assert property (
    line_code(12, select_low_r, select_high_r) == CODE_SERIAL2_RX |=>
      cpu_int_out[12] == $past(source_events_in[CODE_SERIAL2_RX]))
    else $error("serial source not routed");

  a_turbo_code_route: assert property (
    line_code(15, select_low_r, select_high_r) == CODE_TURBO_UNIT |=>
      cpu_int_out[15] == $past(source_events_in[CODE_TURBO_UNIT]))
    else $error("turbo source not routed");

  a_reserved_flagged: assert property (
    wr_fire && wb_req_in.adr == ADDR_SELECT_HIGH && wb_req_in.sel == 4'hF &&
    wb_req_in.dat[4:0] == 5'h15 |=> status_r[EVT_RESERVED_CODE] ##1 1'b1)
    else $error("reserved code not flagged");

  a_ack_single: assert property (
    ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// [sim/event_source_model.sv]
`default_nettype none
// ****************************************************************
// Peripheral event sources seen by the selector
// ****************************************************************
module event_source_model (
  // Commands from the bench
  input wire logic [4:0] code_in,
  input wire logic one_in,
  input wire logic all_in,
  input wire logic [1:0] fixed_in,
  // Event lines toward the selector
  output logic [31:0] source_events_out,
  output logic reset_event_out,
  output logic nmi_event_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // One source per code, or every source at once to expose stray routing
  assign source_events_out = all_in ? 32'hFFFF_FFFF :
                             (one_in ? (32'h0000_0001 << code_in) : 32'h0000_0000);
  // Fixed lines are plain levels from the core's own event logic
  assign reset_event_out = fixed_in[0];
  assign nmi_event_out = fixed_in[1];
endmodule
`default_nettype wire

// [sim/test_cpu_interrupt_selector.sv]
`default_nettype none
module test_cpu_interrupt_selector;
  timeunit 1ns;
  timeprecision 1ns;
  import cpu_int_sel_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock_in;
  logic rst_in;
  wb_req_t wb_req; // Bus request, changed only just after an edge
  wb_rsp_t wb_rsp;
  logic [4:0] ev_code; // Source the partner raises
  logic ev_one;
  logic ev_all;
  logic [1:0] ev_fixed;
  logic [31:0] src_ev;
  logic rst_ev;
  logic nmi_ev;
  logic [15:0] cpu_int;
  logic irq;
  logic [31:0] rd; // Last read data
  int num_errors = 0;
  int samples_checked = 0;
  // Default source of lines 4 to 15
  localparam logic [4:0] DFLT [4:15] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                                         5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
  // Every code that names a real source
  localparam logic [4:0] VALID [24] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10,
    5'h11, 5'h12, 5'h13, 5'h14, 5'h17, 5'h1E, 5'h1F};
  localparam logic [31:0] LOW_DFLT = {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04};
  localparam logic [31:0] HIGH_DFLT = {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03};
  // ****************************************************************
  // Design and partner
  // ****************************************************************
  cpu_interrupt_selector dut (.clock_in(clock_in), .rst_in(rst_in), .wb_req_in(wb_req),
    .wb_rsp_out(wb_rsp), .reset_event_in(rst_ev), .nmi_event_in(nmi_ev),
    .source_events_in(src_ev), .cpu_int_out(cpu_int), .irq_out(irq));
  event_source_model peer (.code_in(ev_code), .one_in(ev_one), .all_in(ev_all),
    .fixed_in(ev_fixed), .source_events_out(src_ev), .reset_event_out(rst_ev),
    .nmi_event_out(nmi_ev));
  // Free running clock
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Same code in all six fields; bits 15 and 31 stay clear
  function automatic logic [31:0] fill(input logic [4:0] c);
    fill = {1'b0, c, c, c, 1'b0, c, c, c};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle; entered just after an edge, leaves one idle cycle
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat, sel: sel};
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    // A missing ack must not hang the bench
    if (n >= 20) begin
      chk("bus ack", 32'h0000_0001, 32'h0000_0000);
    end
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clock_in);
  endtask
  // Change the partner's events; two edges cover the registered output
  task automatic route(input logic [4:0] c, input logic one, input logic all,
                       input logic [1:0] fx);
    ev_code <= c;
    ev_one <= one;
    ev_all <= all;
    ev_fixed <= fx;
    repeat (2) @(posedge clock_in);
  endtask
  // Reset with events on, so a cleared output is not luck
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("lines in reset", 32'h0000_0000, {16'h0000, cpu_int});
    rst_in <= 1'b0;
    @(posedge clock_in);
    wb(1'b0, ADDR_SELECT_LOW, 32'h0000_0000, 4'hF);
    chk("low after reset", LOW_DFLT, rd);
    wb(1'b0, ADDR_SELECT_HIGH, 32'h0000_0000, 4'hF);
    chk("high after reset", HIGH_DFLT, rd);
  endtask
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_in = 1'b1;
    wb_req = '0;
    ev_code = 5'h00;
    ev_one = 1'b0;
    ev_all = 1'b1;
    ev_fixed = 2'b11;
    do_reset();
    // Each default source reaches only its own line
    for (int l = 4; l <= 15; l++) begin
      route(DFLT[l], 1'b1, 1'b0, 2'b00);
      chk("default line", 32'h0000_0001 << l, {16'h0000, cpu_int});
    end
    // Fixed lines pass through, reserved lines stay low
    route(5'h00, 1'b0, 1'b1, 2'b11);
    chk("fixed lines", 32'h0000_FFF3, {16'h0000, cpu_int});
    // Every valid code, one cycle after its write
    foreach (VALID[i]) begin
      route(VALID[i], 1'b1, 1'b0, 2'b00);
      wb(1'b1, ADDR_SELECT_LOW, fill(VALID[i]), 4'hF);
      @(posedge clock_in);
      chk("low lines", 32'h0000_003F, {26'h0, cpu_int[9:4]});
      wb(1'b1, ADDR_SELECT_HIGH, fill(VALID[i]), 4'hF);
      @(posedge clock_in);
      chk("all lines", 32'h0000_FFF0, {16'h0000, cpu_int});
      wb(1'b0, ADDR_SELECT_HIGH, 32'h0000_0000, 4'hF);
      chk("high readback", fill(VALID[i]), rd);
    end
    // Status, mask and the level output
    wb(1'b0, ADDR_EVENT_STATUS, 32'h0000_0000, 4'hF);
    chk("status", 32'h0000_0002, rd);
    wb(1'b1, ADDR_EVENT_MASK, 32'h0000_0003, 4'hF);
    @(posedge clock_in);
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    wb(1'b1, ADDR_EVENT_STATUS, 32'h0000_0002, 4'hF);
    @(posedge clock_in);
    chk("irq clear", 32'h0000_0000, {31'h0, irq});
    // Unused bits never store
    wb(1'b1, ADDR_SELECT_LOW, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, ADDR_SELECT_LOW, 32'h0000_0000, 4'hF);
    chk("unused bits", 32'h7FFF_7FFF, rd);
    // Lane 0 only: field 1 becomes a reserved code on purpose
    wb(1'b1, ADDR_SELECT_LOW, 32'h0000_0000, 4'h1);
    wb(1'b0, ADDR_SELECT_LOW, 32'h0000_0000, 4'hF);
    chk("lane write", 32'h7FFF_7F00, rd);
    // Full-word write with a reserved code in the field of line ten
    wb(1'b1, ADDR_SELECT_HIGH, 32'h7FFF_7FF5, 4'hF);
    route(5'h00, 1'b0, 1'b1, 2'b00);
    chk("reserved line", 32'h0000_FBD0, {16'h0000, cpu_int});
    wb(1'b0, ADDR_EVENT_STATUS, 32'h0000_0000, 4'hF);
    chk("status both", 32'h0000_0003, rd);
    chk("irq again", 32'h0000_0001, {31'h0, irq});
    wb(1'b0, ADDR_EVENT_MASK, 32'h0000_0000, 4'hF);
    chk("mask", 32'h0000_0003, rd);
    wb(1'b1, ADDR_EVENT_STATUS, 32'h0000_0003, 4'hF);
    @(posedge clock_in);
    chk("irq final", 32'h0000_0000, {31'h0, irq});
    // Unmapped place acks, ignores writes, reads zero
    wb(1'b1, 32'h019C_0010, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 32'h019C_0010, 32'h0000_0000, 4'hF);
    chk("unmapped", 32'h0000_0000, rd);
    // Second reset in mid-run restores the defaults
    route(5'h00, 1'b0, 1'b1, 2'b11);
    do_reset();
    close_out();
  end
  // Run needs under 2000 cycles; a hang ends as a failure
  initial begin
    repeat (5000) @(posedge clock_in);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
